// ===== psi_proc_end.sv
// Processor end of the system interface: clocks, bus master, resets, interrupts
`timescale 1ns/100ps
`default_nettype none
module psi_proc_end #(
  parameter int HALF_CYC = psi_pkg::TCLK_HALF_CYC
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  psi_if.proc LINK,
  input wire logic POWER_ON_INIT_IN,
  input wire logic WARM_RESET_IN,
  input wire logic [psi_pkg::INT_N-1:0] INT_IN,
  input wire logic [psi_pkg::INT_N-1:0] INT_MASK,
  input wire logic NMI_IN,
  input wire logic DESKEW_CLOCK_IN,
  input wire logic TX_VALID,
  output logic TX_READY,
  input wire logic [psi_pkg::AD_W-1:0] TX_ADDR,
  input wire logic [psi_pkg::CMD_W-1:0] TX_CMD,
  input wire logic TX_HAS_DATA,
  input wire logic [psi_pkg::AD_W-1:0] TX_DATA,
  input wire logic [psi_pkg::CMD_W-1:0] TX_DATA_ID,
  output logic RX_VALID,
  output logic [psi_pkg::AD_W-1:0] RX_WORD,
  output logic [psi_pkg::CMD_W-1:0] RX_CMD,
  output logic [psi_pkg::CAUSE_W-1:0] CAUSE,
  output logic INT_REQ,
  output logic NMI_REQ,
  output logic RESET_EXC,
  output logic PROTOCOL_ERROR,
  output logic DESKEW_LOCKED
);
  localparam int CNT_W = $clog2(HALF_CYC + 1);
  localparam int MISS_W = $clog2(psi_pkg::DESKEW_MISS_LIMIT + 1);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1);
  localparam logic [MISS_W-1:0] MISS_MAX = MISS_W'(psi_pkg::DESKEW_MISS_LIMIT);

  // Cold reset: asserts asynchronously, releases on the clock [R12]
  logic cold_n;
  logic [psi_pkg::RST_SYNC_STAGES-1:0] rst_chain_reg;
  logic rst_n;
  assign cold_n = RSTN & ~POWER_ON_INIT_IN;
  always_ff @(posedge CLK or negedge cold_n) begin
    if (!cold_n) begin
      rst_chain_reg <= '0;
    end else begin
      rst_chain_reg <= {rst_chain_reg[psi_pkg::RST_SYNC_STAGES-2:0], 1'b1}; // [R12]
    end
  end
  assign rst_n = rst_chain_reg[psi_pkg::RST_SYNC_STAGES-1];

  // Pin inputs from outside the clock domain
  logic [psi_pkg::INT_N-1:0] int_s;
  logic nmi_s;
  logic warm_s;
  logic deskew_s;
  psi_sync #(.W(psi_pkg::INT_N + 3)) u_sync (
    .clk(CLK),
    .rst_n(rst_n),
    .ce(CE),
    .d({INT_IN, NMI_IN, WARM_RESET_IN, DESKEW_CLOCK_IN}),
    .q({int_s, nmi_s, warm_s, deskew_s})
  );

  // Interface clock divider; tick marks the coming rising edge [R14]
  logic [CNT_W-1:0] div_reg;
  logic ifclk_reg;
  logic half_tick;
  logic tick;
  assign half_tick = (div_reg == HALF_LAST);
  assign tick = half_tick & ~ifclk_reg;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= '0;
      ifclk_reg <= 1'b0;
    end else if (CE) begin
      div_reg <= half_tick ? '0 : div_reg + 1'b1;
      if (half_tick) begin
        ifclk_reg <= ~ifclk_reg; // [R14]
      end
    end
  end
  assign LINK.interface_clock_out = ifclk_reg;
  assign LINK.deskew_clock_out = ifclk_reg; // [R15]

  // Deskew loop: returned clock must keep toggling with the one sent out
  logic deskew_q_reg;
  logic [MISS_W-1:0] miss_reg;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      deskew_q_reg <= 1'b0;
      miss_reg <= MISS_MAX;
    end else if (CE) begin
      deskew_q_reg <= deskew_s;
      if (deskew_s != deskew_q_reg) begin
        miss_reg <= '0; // [R15]
      end else if (half_tick && miss_reg != MISS_MAX) begin
        miss_reg <= miss_reg + 1'b1;
      end
    end
  end
  assign DESKEW_LOCKED = (miss_reg != MISS_MAX);

  // Interrupt view: live inputs in the cause field, NMI bypasses the mask
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      CAUSE <= '0;
      INT_REQ <= 1'b0;
      NMI_REQ <= 1'b0;
    end else if (CE) begin
      CAUSE[psi_pkg::CAUSE_IP_MSB:psi_pkg::CAUSE_IP_LSB] <= int_s; // [R10]
      INT_REQ <= |(int_s & INT_MASK);
      NMI_REQ <= nmi_s; // [R11]
    end
  end

  // Warm reset only flags an exception; bus and interrupt state stay put
  logic warm_q_reg;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      warm_q_reg <= 1'b0;
      RESET_EXC <= 1'b0;
    end else if (CE) begin
      warm_q_reg <= warm_s;
      RESET_EXC <= warm_s & ~warm_q_reg; // [R13]
    end
  end

  // Bus master state machine, advanced on interface clock rising edges
  psi_pkg::psi_pstate_e state_reg;
  logic [psi_pkg::AD_W-1:0] data_reg;
  logic [psi_pkg::CMD_W-1:0] data_id_reg;
  logic has_data_reg;
  logic grant;
  logic proto_err;
  assign grant = TX_VALID & ~LINK.agent_bus_request & LINK.agent_accept_ready; // [R9]
  assign TX_READY = CE & tick & (state_reg == psi_pkg::PSI_P_IDLE) & grant;
  // Agent driving while the processor owns the bus is a protocol error
  assign proto_err = LINK.agent_drive_valid & LINK.proc_owns_bus;
  assign PROTOCOL_ERROR = (state_reg == psi_pkg::PSI_P_ERROR);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= psi_pkg::PSI_P_IDLE;
      data_reg <= '0;
      data_id_reg <= '0;
      has_data_reg <= 1'b0;
      LINK.proc_ad_o <= '0;
      LINK.proc_cmd_o <= '0;
      LINK.proc_ad_oe_n <= 1'b1;
      LINK.proc_drive_valid <= 1'b0;
      LINK.proc_owns_bus <= 1'b0;
    end else if (CE && tick) begin // [R16]
      if (proto_err || state_reg == psi_pkg::PSI_P_ERROR) begin
        // Hang: release the bus and never leave until reset
        state_reg <= psi_pkg::PSI_P_ERROR; // [R7]
        LINK.proc_ad_oe_n <= 1'b1;
        LINK.proc_drive_valid <= 1'b0;
        LINK.proc_owns_bus <= 1'b0;
      end else begin
        unique case (state_reg)
          psi_pkg::PSI_P_IDLE: begin
            if (grant) begin
              data_reg <= TX_DATA;
              data_id_reg <= TX_DATA_ID;
              has_data_reg <= TX_HAS_DATA;
              LINK.proc_ad_o <= TX_ADDR; // [R1]
              LINK.proc_cmd_o <= TX_CMD; // [R2]
              LINK.proc_ad_oe_n <= 1'b0;
              LINK.proc_drive_valid <= 1'b1; // [R4]
              LINK.proc_owns_bus <= 1'b1; // [R8]
              state_reg <= psi_pkg::PSI_P_ADDR;
            end
          end
          psi_pkg::PSI_P_ADDR: begin
            if (has_data_reg) begin
              LINK.proc_ad_o <= data_reg; // [R1]
              LINK.proc_cmd_o <= data_id_reg; // [R2]
              LINK.proc_drive_valid <= 1'b1; // [R4]
              state_reg <= psi_pkg::PSI_P_DATA;
            end else begin
              LINK.proc_ad_oe_n <= 1'b1;
              LINK.proc_drive_valid <= 1'b0;
              LINK.proc_owns_bus <= 1'b0; // [R8]
              state_reg <= psi_pkg::PSI_P_IDLE;
            end
          end
          psi_pkg::PSI_P_DATA: begin
            LINK.proc_ad_oe_n <= 1'b1;
            LINK.proc_drive_valid <= 1'b0;
            LINK.proc_owns_bus <= 1'b0; // [R8]
            state_reg <= psi_pkg::PSI_P_IDLE;
          end
          default: begin
            state_reg <= psi_pkg::PSI_P_ERROR;
          end
        endcase
      end
    end
  end

  // Request: held while TX_VALID waits for a grant, dropped once granted; oscillates once in error
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      LINK.proc_bus_request <= 1'b0;
    end else if (CE) begin
      if (state_reg == psi_pkg::PSI_P_ERROR) begin
        if (half_tick) begin
          LINK.proc_bus_request <= ~LINK.proc_bus_request; // [R7]
        end
      end else if (tick) begin
        LINK.proc_bus_request <= TX_VALID & ~grant & ~proto_err; // [R6]
      end
    end
  end

  // Receive words the agent marks valid while it holds the bus
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RX_VALID <= 1'b0;
      RX_WORD <= '0;
      RX_CMD <= '0;
    end else if (CE) begin
      RX_VALID <= 1'b0;
      if (tick && !LINK.proc_owns_bus && LINK.agent_drive_valid
          && state_reg != psi_pkg::PSI_P_ERROR) begin // [R3]
        RX_VALID <= 1'b1;
        RX_WORD <= LINK.addr_data_bus;
        RX_CMD <= LINK.cmd_id_bus;
      end
    end
  end
endmodule
`default_nettype wire

// ===== psi_pkg.sv
// Shared constants and state types for the processor system interface ends
// Functional notes
// R1: One shared 32-bit bus carries address or data
// R2: 5-bit bus carries command or data identifier
// R3: Agent valid marks its driven address or data
// R4: Processor valid marks its driven address or data
// R5: Agent raises request when it needs the interface
// R6: Processor raises request to issue a transaction
// R7: Protocol error: request toggles, all activity stops
// R8: Ownership output high only while processor is master
// R9: Agent accept-ready only when it can accept
// R10: Interrupt inputs shown live in cause bits 14:10
// R11: Non-maskable interrupt ignores every mask
// R12: Cold reset initialises state, accepted asynchronously
// R13: Warm reset raises exception, keeps internal state
// R14: Processor outputs interface clock derived from master clock
// R15: Processor drives and checks deskew clock loop
// R16: Both sample the link on interface clock rising edges
package psi_pkg;
  localparam int AD_W = 32;
  localparam int CMD_W = 5;
  localparam int INT_N = 5;
  localparam int CAUSE_W = 32;
  localparam int CAUSE_IP_LSB = 10;
  localparam int CAUSE_IP_MSB = 14;
  localparam int SYNC_STAGES = 3;
  localparam int RST_SYNC_STAGES = 2;
  localparam int CLK_PERIOD_NS = 8;
  localparam int TCLK_HALF_NS = 16;
  localparam int TCLK_HALF_CYC = TCLK_HALF_NS / CLK_PERIOD_NS;
  localparam int DESKEW_MISS_LIMIT = 4;

  typedef enum logic [2:0] {
    PSI_P_IDLE = 3'h0,
    PSI_P_ADDR = 3'h1,
    PSI_P_DATA = 3'h2,
    PSI_P_ERROR = 3'h3
  } psi_pstate_e;

  typedef enum logic [1:0] {
    PSI_A_IDLE = 2'h0,
    PSI_A_WAIT = 2'h1,
    PSI_A_ADDR = 2'h2,
    PSI_A_DATA = 2'h3
  } psi_astate_e;
endpackage

// ===== psi_if.sv
// Link between the processor end and the external agent end
`timescale 1ns/100ps
`default_nettype none
interface psi_if;
  logic interface_clock_out;
  logic deskew_clock_out;
  logic [psi_pkg::AD_W-1:0] proc_ad_o;
  logic proc_ad_oe_n;
  logic [psi_pkg::AD_W-1:0] agent_ad_o;
  logic agent_ad_oe_n;
  logic [psi_pkg::CMD_W-1:0] proc_cmd_o;
  logic [psi_pkg::CMD_W-1:0] agent_cmd_o;
  logic [psi_pkg::AD_W-1:0] addr_data_bus;
  logic [psi_pkg::CMD_W-1:0] cmd_id_bus;
  logic proc_drive_valid;
  logic proc_bus_request;
  logic proc_owns_bus;
  logic agent_drive_valid;
  logic agent_bus_request;
  logic agent_accept_ready;

  // Shared wires resolve to the enabled driver; undriven reads as zero
  assign addr_data_bus = !proc_ad_oe_n ? proc_ad_o :
                         !agent_ad_oe_n ? agent_ad_o : '0;
  assign cmd_id_bus = !proc_ad_oe_n ? proc_cmd_o :
                      !agent_ad_oe_n ? agent_cmd_o : '0;

  modport proc (
    output interface_clock_out, deskew_clock_out, proc_ad_o, proc_ad_oe_n,
    output proc_cmd_o, proc_drive_valid, proc_bus_request, proc_owns_bus,
    input addr_data_bus, cmd_id_bus, agent_drive_valid, agent_bus_request,
    input agent_accept_ready
  );
  modport agent (
    output agent_ad_o, agent_ad_oe_n, agent_cmd_o, agent_drive_valid,
    output agent_bus_request, agent_accept_ready,
    input interface_clock_out, addr_data_bus, cmd_id_bus, proc_drive_valid,
    input proc_bus_request, proc_owns_bus
  );
endinterface
`default_nettype wire

// ===== psi_sync.sv
// Three-stage input synchroniser with agreement filter, one per bit
`timescale 1ns/100ps
`default_nettype none
module psi_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
        end else if (ce) begin
          s1_reg <= d[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
        end
      end
      // A change is taken only once the last two stages agree
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          q[i] <= 1'b0;
        end else if (ce && (s2_reg == s3_reg)) begin
          q[i] <= s3_reg;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== psi_agent_end.sv
// External agent end of the system interface
`timescale 1ns/100ps
`default_nettype none
module psi_agent_end (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  psi_if.agent LINK,
  input wire logic TX_VALID,
  output logic TX_READY,
  input wire logic [psi_pkg::AD_W-1:0] TX_ADDR,
  input wire logic [psi_pkg::CMD_W-1:0] TX_CMD,
  input wire logic TX_HAS_DATA,
  input wire logic [psi_pkg::AD_W-1:0] TX_DATA,
  input wire logic [psi_pkg::CMD_W-1:0] TX_DATA_ID,
  output logic RX_VALID,
  output logic [psi_pkg::AD_W-1:0] RX_WORD,
  output logic [psi_pkg::CMD_W-1:0] RX_CMD
);
  // Link signals share CLK, so the interface clock edge is found directly
  logic ifclk_q_reg;
  logic tick;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ifclk_q_reg <= 1'b0;
    end else if (CE) begin
      ifclk_q_reg <= LINK.interface_clock_out;
    end
  end
  assign tick = LINK.interface_clock_out & ~ifclk_q_reg; // [R16]

  psi_pkg::psi_astate_e state_reg;
  logic [psi_pkg::AD_W-1:0] data_reg;
  logic [psi_pkg::CMD_W-1:0] data_id_reg;
  logic has_data_reg;
  // Waiting one edge lets a processor grant taken the same edge win cleanly
  assign TX_READY = CE & tick & (state_reg == psi_pkg::PSI_A_WAIT) & ~LINK.proc_owns_bus;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= psi_pkg::PSI_A_IDLE;
      data_reg <= '0;
      data_id_reg <= '0;
      has_data_reg <= 1'b0;
      LINK.agent_ad_o <= '0;
      LINK.agent_cmd_o <= '0;
      LINK.agent_ad_oe_n <= 1'b1;
      LINK.agent_drive_valid <= 1'b0;
      LINK.agent_bus_request <= 1'b0;
      // Reset leaves the agent idle, so it can take a processor request at once
      LINK.agent_accept_ready <= 1'b1; // [R9]
    end else if (CE && tick) begin // [R16]
      unique case (state_reg)
        psi_pkg::PSI_A_IDLE: begin
          LINK.agent_bus_request <= TX_VALID; // [R5]
          LINK.agent_accept_ready <= ~TX_VALID; // [R9]
          if (TX_VALID) begin
            state_reg <= psi_pkg::PSI_A_WAIT;
          end
        end
        psi_pkg::PSI_A_WAIT: begin
          if (!LINK.proc_owns_bus) begin
            data_reg <= TX_DATA;
            data_id_reg <= TX_DATA_ID;
            has_data_reg <= TX_HAS_DATA;
            LINK.agent_ad_o <= TX_ADDR; // [R1]
            LINK.agent_cmd_o <= TX_CMD; // [R2]
            LINK.agent_ad_oe_n <= 1'b0;
            LINK.agent_drive_valid <= 1'b1; // [R3]
            state_reg <= psi_pkg::PSI_A_ADDR;
          end
        end
        psi_pkg::PSI_A_ADDR: begin
          if (has_data_reg) begin
            LINK.agent_ad_o <= data_reg; // [R1]
            LINK.agent_cmd_o <= data_id_reg; // [R2]
            state_reg <= psi_pkg::PSI_A_DATA;
          end else begin
            LINK.agent_ad_oe_n <= 1'b1;
            LINK.agent_drive_valid <= 1'b0;
            LINK.agent_bus_request <= 1'b0;
            LINK.agent_accept_ready <= 1'b1;
            state_reg <= psi_pkg::PSI_A_IDLE;
          end
        end
        psi_pkg::PSI_A_DATA: begin
          LINK.agent_ad_oe_n <= 1'b1;
          LINK.agent_drive_valid <= 1'b0;
          LINK.agent_bus_request <= 1'b0;
          LINK.agent_accept_ready <= 1'b1;
          state_reg <= psi_pkg::PSI_A_IDLE;
        end
      endcase
    end
  end

  // Capture processor words on interface clock rising edges
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RX_VALID <= 1'b0;
      RX_WORD <= '0;
      RX_CMD <= '0;
    end else if (CE) begin
      RX_VALID <= 1'b0;
      if (tick && LINK.proc_drive_valid) begin // [R4]
        RX_VALID <= 1'b1;
        RX_WORD <= LINK.addr_data_bus;
        RX_CMD <= LINK.cmd_id_bus;
      end
    end
  end
endmodule
`default_nettype wire

// ===== psi_link_assertions.sv
// Concurrent checks on the link between the processor end and the agent end
`timescale 1ns/100ps
`default_nettype none
module psi_link_assertions #(
  parameter int HALF_CYC = psi_pkg::TCLK_HALF_CYC
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic POWER_ON_INIT_IN,
  input wire logic interface_clock_out,
  input wire logic deskew_clock_out,
  input wire logic [psi_pkg::AD_W-1:0] proc_ad_o,
  input wire logic proc_ad_oe_n,
  input wire logic [psi_pkg::AD_W-1:0] agent_ad_o,
  input wire logic agent_ad_oe_n,
  input wire logic [psi_pkg::CMD_W-1:0] proc_cmd_o,
  input wire logic [psi_pkg::CMD_W-1:0] agent_cmd_o,
  input wire logic [psi_pkg::AD_W-1:0] addr_data_bus,
  input wire logic [psi_pkg::CMD_W-1:0] cmd_id_bus,
  input wire logic proc_drive_valid,
  input wire logic proc_owns_bus,
  input wire logic agent_drive_valid,
  input wire logic agent_bus_request,
  input wire logic agent_accept_ready
);
  default clocking cb @(posedge CLK); endclocking
  // Cold reset also clears the processor end, so it silences the checks
  default disable iff (!RSTN || POWER_ON_INIT_IN);

  sequence half_high_s;
    interface_clock_out ##1 !interface_clock_out;
  endsequence
  sequence word_hold_s;
    proc_drive_valid[*4];
  endsequence

  ifclk_rate_a: assert property ($rose(interface_clock_out) |-> ##1 half_high_s)
    else $error("interface clock high phase has wrong length");
  deskew_copy_a: assert property ($changed(interface_clock_out) |-> ##[0:1]
    (deskew_clock_out == interface_clock_out))
    else $error("deskew clock does not follow interface clock");
  proc_drive_a: assert property (proc_drive_valid |-> !proc_ad_oe_n &&
    addr_data_bus == proc_ad_o && cmd_id_bus == proc_cmd_o)
    else $error("processor valid without its word on the buses");
  agent_drive_a: assert property (agent_drive_valid |-> !agent_ad_oe_n &&
    addr_data_bus == agent_ad_o && cmd_id_bus == agent_cmd_o)
    else $error("agent valid without its word on the buses");
  one_driver_a: assert property (proc_ad_oe_n || agent_ad_oe_n)
    else $error("both ends drive the shared buses");
  owner_flag_a: assert property (proc_owns_bus == !proc_ad_oe_n)
    else $error("ownership flag disagrees with processor drive");
  word_hold_a: assert property ($rose(proc_drive_valid) |-> word_hold_s)
    else $error("processor word shorter than one interface period");
  agent_ready_a: assert property (agent_accept_ready == !agent_bus_request)
    else $error("agent accept ready while it requests the link");
  agent_req_a: assert property ($rose(agent_drive_valid) |-> $past(agent_bus_request, 2))
    else $error("agent drove a word without requesting the link");
endmodule
`default_nettype wire

// ===== processor_system_interface_signals_tb.sv
// Bench joining both ends, plus a processor end facing a faulty agent
`timescale 1ns/100ps
`default_nettype none
module processor_system_interface_signals_tb;
  logic clk, rstn, pinit, warm, nmi, dsk_sel, tx_valid_e, perr, perr_e, lock, rexc;
  logic int_req, nmi_req, prev;
  logic [4:0] int_in, int_mask;
  logic [31:0] cause;
  logic tx_valid[2], tx_ready[2], tx_hd[2], rx_valid[2];
  logic [31:0] tx_addr[2], tx_data[2], rx_word[2];
  logic [4:0] tx_cmd[2], tx_id[2], rx_cmd[2];
  logic [36:0] exp_q[2][$], got_q[2][$], wq[$], ew[$], last_w;
  int err_count, compares, cnt, vcnt;
  psi_if link();
  psi_if link_e();

  psi_proc_end i_psi_proc_end (.CLK(clk), .RSTN(rstn), .CE(1'b1), .LINK(link),
    .POWER_ON_INIT_IN(pinit), .WARM_RESET_IN(warm), .INT_IN(int_in), .INT_MASK(int_mask),
    .NMI_IN(nmi), .DESKEW_CLOCK_IN(dsk_sel & link.deskew_clock_out),
    .TX_VALID(tx_valid[0]), .TX_READY(tx_ready[0]), .TX_ADDR(tx_addr[0]), .TX_CMD(tx_cmd[0]),
    .TX_HAS_DATA(tx_hd[0]), .TX_DATA(tx_data[0]), .TX_DATA_ID(tx_id[0]),
    .RX_VALID(rx_valid[1]), .RX_WORD(rx_word[1]), .RX_CMD(rx_cmd[1]), .CAUSE(cause),
    .INT_REQ(int_req), .NMI_REQ(nmi_req), .RESET_EXC(rexc), .PROTOCOL_ERROR(perr),
    .DESKEW_LOCKED(lock));
  psi_agent_end i_psi_agent_end (.CLK(clk), .RSTN(rstn), .CE(1'b1), .LINK(link),
    .TX_VALID(tx_valid[1]), .TX_READY(tx_ready[1]), .TX_ADDR(tx_addr[1]), .TX_CMD(tx_cmd[1]),
    .TX_HAS_DATA(tx_hd[1]), .TX_DATA(tx_data[1]), .TX_DATA_ID(tx_id[1]),
    .RX_VALID(rx_valid[0]), .RX_WORD(rx_word[0]), .RX_CMD(rx_cmd[0]));
  // Second processor end: its agent side is driven by hand to break the protocol
  psi_proc_end i_psi_proc_end_err (.CLK(clk), .RSTN(rstn), .CE(1'b1), .LINK(link_e),
    .POWER_ON_INIT_IN(pinit), .WARM_RESET_IN(warm), .INT_IN(int_in), .INT_MASK(int_mask),
    .NMI_IN(nmi), .DESKEW_CLOCK_IN(link_e.deskew_clock_out), .TX_VALID(tx_valid_e),
    .TX_READY(), .TX_ADDR(tx_addr[0]), .TX_CMD(tx_cmd[0]), .TX_HAS_DATA(tx_hd[0]),
    .TX_DATA(tx_data[0]), .TX_DATA_ID(tx_id[0]), .RX_VALID(), .RX_WORD(), .RX_CMD(),
    .CAUSE(), .INT_REQ(), .NMI_REQ(), .RESET_EXC(), .PROTOCOL_ERROR(perr_e),
    .DESKEW_LOCKED());
  psi_link_assertions i_psi_link_assertions (.CLK(clk), .RSTN(rstn), .POWER_ON_INIT_IN(pinit),
    .interface_clock_out(link.interface_clock_out), .deskew_clock_out(link.deskew_clock_out),
    .proc_ad_o(link.proc_ad_o), .proc_ad_oe_n(link.proc_ad_oe_n),
    .agent_ad_o(link.agent_ad_o), .agent_ad_oe_n(link.agent_ad_oe_n),
    .proc_cmd_o(link.proc_cmd_o), .agent_cmd_o(link.agent_cmd_o),
    .addr_data_bus(link.addr_data_bus), .cmd_id_bus(link.cmd_id_bus),
    .proc_drive_valid(link.proc_drive_valid), .proc_owns_bus(link.proc_owns_bus),
    .agent_drive_valid(link.agent_drive_valid), .agent_bus_request(link.agent_bus_request),
    .agent_accept_ready(link.agent_accept_ready));

  initial begin
    clk = 1'b0;
    forever begin
      #4 clk = ~clk;
    end
  end

  // Words are collected at the falling edge, where registered outputs have settled
  always @(negedge clk) begin
    for (int s = 0; s < 2; s++) begin
      if (rx_valid[s] === 1'b1) got_q[s].push_back({rx_cmd[s], rx_word[s]});
    end
    if (link.proc_drive_valid === 1'b1 && {link.cmd_id_bus, link.addr_data_bus} !== last_w)
      wq.push_back({link.cmd_id_bus, link.addr_data_bus});
    last_w = (link.proc_drive_valid === 1'b1) ? {link.cmd_id_bus, link.addr_data_bus} : 'x;
  end

  task automatic stop_test;
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic tmo;
    err_count++;
    $display("mismatch at %0t: wait ran out, seen 0x0 expected 0x1", $time);
    stop_test();
  endtask

  task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask

  // Request stays up until the end reports it taken, then drops a cycle later
  task automatic send(input int s, input logic [31:0] a, input logic [4:0] c, input logic hd,
                      input logic [31:0] d, input logic [4:0] id);
    int n;
    n = 0;
    @(negedge clk);
    tx_addr[s] = a;
    tx_cmd[s] = c;
    tx_hd[s] = hd;
    tx_data[s] = d;
    tx_id[s] = id;
    tx_valid[s] = 1'b1;
    exp_q[s].push_back({c, a});
    if (hd) exp_q[s].push_back({id, d});
    #1;
    while (tx_ready[s] !== 1'b1) begin
      if (n++ > 400) tmo();
      @(negedge clk);
      #1;
    end
    @(negedge clk);
    tx_valid[s] = 1'b0;
  endtask

  task automatic drain(input int s);
    int n;
    n = 0;
    while (got_q[s].size() < exp_q[s].size()) begin
      if (n++ > 600) tmo();
      @(negedge clk);
    end
    while (exp_q[s].size() > 0) chk(got_q[s].pop_front(), exp_q[s].pop_front());
    chk(37'(got_q[s].size()), 37'h0);
  endtask

  initial begin
    {rstn, pinit, warm, nmi, tx_valid_e, int_in, int_mask, last_w} = '0;
    dsk_sel = 1'b1;
    for (int s = 0; s < 2; s++) begin
      {tx_valid[s], tx_hd[s], tx_addr[s], tx_data[s], tx_cmd[s], tx_id[s]} = '0;
    end
    {link_e.agent_ad_o, link_e.agent_cmd_o, link_e.agent_drive_valid} = '0;
    {link_e.agent_ad_oe_n, link_e.agent_bus_request, link_e.agent_accept_ready} = 3'h5;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      send(0, 32'hFFFF_FFFF >> (8 * i), 5'(i * 7), 1'(i & 1), ~(32'h1 << i), 5'h1F - 5'(i));
    end
    ew = exp_q[0];
    drain(0);
    foreach (ew[k]) chk(wq[k], ew[k]);
    send(1, 32'h0000_0000, 5'h1F, 1'b1, 32'hA5A5_5A5A, 5'h00);
    send(1, 32'h8000_0001, 5'h0C, 1'b0, 32'h0, 5'h0);
    drain(1);
    fork
      send(0, 32'h1234_5678, 5'h03, 1'b1, 32'h9ABC_DEF0, 5'h11);
      send(1, 32'h0F0F_0F0F, 5'h15, 1'b1, 32'hF0F0_F0F0, 5'h0A);
    join
    drain(0);
    drain(1);
    chk(37'({perr, link.proc_bus_request}), 37'h0);
    for (int i = 0; i < 6; i++) begin
      int_in = (i == 5) ? 5'h1F : 5'(1 << i);
      int_mask = i[0] ? 5'h00 : 5'h1B;
      nmi = i[0];
      repeat (8) @(negedge clk);
      chk({5'h0, cause}, {22'h0, int_in, 10'h0});
      chk(37'({int_req, nmi_req}), 37'({|(int_in & int_mask), nmi}));
    end
    warm = 1'b1;
    cnt = 0;
    repeat (12) begin
      @(negedge clk);
      cnt += (rexc === 1'b1);
    end
    warm = 1'b0;
    chk(37'(cnt), 37'h1);
    chk(37'({lock, cause[14:10]}), 37'h3F);
    dsk_sel = 1'b0;
    repeat (30) @(negedge clk);
    chk(37'(lock), 37'h0);
    dsk_sel = 1'b1;
    repeat (30) @(negedge clk);
    chk(37'(lock), 37'h1);
    tx_valid_e = 1'b1;
    cnt = 0;
    while (link_e.proc_owns_bus !== 1'b1) begin
      if (cnt++ > 200) tmo();
      @(negedge clk);
    end
    link_e.agent_drive_valid = 1'b1;
    repeat (8) @(negedge clk);
    link_e.agent_drive_valid = 1'b0;
    repeat (4) @(negedge clk);
    {cnt, vcnt, prev} = {64'h0, link_e.proc_bus_request};
    repeat (16) begin
      @(negedge clk);
      cnt += (link_e.proc_bus_request !== prev);
      vcnt += (link_e.proc_drive_valid === 1'b1);
      prev = link_e.proc_bus_request;
    end
    chk(37'({perr_e, link_e.proc_owns_bus, link_e.proc_ad_oe_n}), 37'h5);
    chk(37'({cnt[7:0], vcnt[7:0]}), 37'h800);
    // Cold reset lands mid-cycle to show it needs no clock alignment
    tx_valid_e = 1'b0;
    #2 pinit = 1'b1;
    repeat (2) @(negedge clk);
    chk(37'({perr_e, lock, link.proc_owns_bus, cause}), 37'h0);
    pinit = 1'b0;
    repeat (8) @(negedge clk);
    chk(37'(perr_e), 37'h0);
    send(0, 32'hC0DE_0001, 5'h02, 1'b0, 32'h0, 5'h0);
    drain(0);
    stop_test();
  end
endmodule
`default_nettype wire
